// File: inc/watchdog_pkg.sv
// Package for the watchdog with clear key: register map, field
// layout, reset values, counter geometry and the carrier structs.
// Assumes a byte-wide CPU bus with a 16-bit address space.
package watchdog_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] CONFIG_ADDR = 16'hff98;
   localparam logic [15:0] KEY_ADDR = 16'hff99;

   // ==========================================================
   // Reset values and key codes
   localparam logic [7:0] CONFIG_RESET = 8'h67;
   localparam logic [7:0] KEY_READ_VALUE = 8'h9a;
   localparam logic [7:0] KEY_CLEAR_VALUE = 8'hac;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================================
   // Configuration field positions
   localparam int HALT_BIT = 4;
   localparam int SOURCE_BIT = 3;
   localparam int INTERVAL_MSB = 2;
   localparam int INTERVAL_LSB = 0;
   localparam logic [1:0] SOURCE_FIELD_OSC = 2'h0;

   // ==========================================================
   // Counter geometry: overflow bit is base exponent plus code
   localparam int COUNT_WIDTH = 21;
   localparam int OSC_BASE_EXP = 11;
   localparam int XTAL_BASE_EXP = 13;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [15:0] addr;    // Byte address
      logic wr;             // Write strobe, one cycle
      logic rd;             // Read strobe, one cycle
      logic bit_op;         // Access is a single-bit manipulation
      logic [7:0] wdata;    // Write data
   } cpu_bus_type;

   typedef struct packed {
      logic halt;           // CPU in HALT
      logic stop;           // CPU in STOP
      logic cpu_on_crystal; // CPU clocked from the crystal
      logic settle_done;    // Oscillator settle time has elapsed
      logic osc_enabled;    // On-chip oscillator not stopped by software
      logic xtal_running;   // Crystal oscillator is running
   } power_state_type;

   typedef enum logic [2:0] {
      PHASE_RUN = 3'b001,
      PHASE_SLEEP = 3'b010,
      PHASE_SETTLE = 3'b100
   } phase_type;

endpackage : watchdog_pkg

// File: design/clock_edge_sync.sv
// Synchroniser for a slow clock arriving on a pin: two flip-flops,
// then a rising-edge detector giving a one-cycle enable pulse.
// Assumes the pin clock is well below half the core clock rate.
`timescale 1ns/10ps
`default_nettype none
module clock_edge_sync (
   input wire logic core_clk,   // Core clock
   input wire logic sys_rst,    // Asynchronous reset, active high
   input wire logic pin_clk,    // Slow clock from outside
   output logic rise_pulse      // One cycle per rising edge
);
   logic meta;
   logic stable;
   logic stable_d;

   // ==========================================================
   // Two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= 1'b0;
         stable <= 1'b0;
         stable_d <= 1'b0;
      end else begin
         meta <= pin_clk;
         stable <= meta;
         stable_d <= stable;
      end
   end

   // Edge detector on the settled copy
   assign rise_pulse = stable & ~stable_d;
endmodule : clock_edge_sync
`default_nettype wire

// File: design/watchdog_counter.sv
// Watchdog up-counter with clear, enable and a selectable overflow
// bit. Assumes the enable is already a one-cycle tick.
`timescale 1ns/10ps
`default_nettype none
module watchdog_counter
   import watchdog_pkg::*;
#(
   parameter int WIDTH = COUNT_WIDTH
) (
   input wire logic core_clk,         // Core clock
   input wire logic sys_rst,          // Asynchronous reset, active high
   input wire logic clear,            // Return count to zero
   input wire logic tick,             // Count one source edge
   input wire logic [4:0] tap,        // Bit index that marks overflow
   output logic [WIDTH-1:0] count,    // Current count
   output logic overflow              // Selected bit reached
);
   // ==========================================================
   // Clear wins over a tick in the same cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (tick) begin
         count <= count + WIDTH'(1);
      end
   end

   // Overflow once the tapped bit has been reached
   assign overflow = count[tap];
endmodule : watchdog_counter
`default_nettype wire

// File: design/watchdog_core.sv
// Watchdog timer with clear key, sitting on the CPU byte bus.
// Assumes the bus strobes and power-state inputs are on core_clk and
// that both watchdog source clocks arrive as slow pin signals.
`timescale 1ns/10ps
`default_nettype none
module watchdog_core
   import watchdog_pkg::*;
#(
   parameter bit ALWAYS_RUN = 1'b0,        // Build option: watchdog cannot stop
   parameter int WIDTH = COUNT_WIDTH        // Counter width
) (
   input wire logic core_clk,                       // 25 MHz core clock
   input wire logic sys_rst,                        // Asynchronous reset, active high
   input wire watchdog_pkg::cpu_bus_type cpu_bus,   // CPU register access
   output logic [7:0] cpu_rdata,                    // Read data, registered
   input wire watchdog_pkg::power_state_type power, // CPU power and clock state
   input wire logic osc_clk_pin,                    // On-chip oscillator clock
   input wire logic xtal_clk_pin,                   // Crystal clock
   output logic wdt_reset,                          // Internal reset request pulse
   output logic [WIDTH-1:0] wdt_count               // Counter value, for observation
);
   import watchdog_pkg::*;

   // ==========================================================
   // Declarations
   logic osc_tick;
   logic xtal_tick;
   logic [7:0] watchdog_config;
   logic config_written;
   logic halt_stopped;
   logic pending_reset;
   logic stop_on_crystal;
   logic cpu_was_on_crystal;
   phase_type phase;
   phase_type next_phase;
   logic use_crystal;
   logic source_active;
   logic source_tick;
   logic count_tick;
   logic overflow;
   logic [4:0] tap;
   logic config_hit;
   logic key_hit;
   logic config_first;
   logic config_second;
   logic key_good;
   logic key_bad;
   logic illegal;
   logic counter_clear;
   logic [7:0] next_config;

   // ==========================================================
   // Functions
   // Overflow bit index for an interval code and a source
   function automatic logic [4:0] overflow_tap(input logic [2:0] code,
                                               input logic crystal);
      logic [4:0] base;
      base = crystal ? 5'(XTAL_BASE_EXP) : 5'(OSC_BASE_EXP);
      return base + {2'h0, code};
   endfunction : overflow_tap

   // Forces the source field when the build option fixes it
   function automatic logic [7:0] accept_config(input logic [7:0] value);
      logic [7:0] result;
      result = value;
      if (ALWAYS_RUN) begin
         result[HALT_BIT:SOURCE_BIT] = SOURCE_FIELD_OSC;
      end
      return result;
   endfunction : accept_config

   // ==========================================================
   // Source clock synchronisers; pins are foreign to core_clk
   clock_edge_sync osc_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_clk(osc_clk_pin),
      .rise_pulse(osc_tick)
   );

   clock_edge_sync xtal_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_clk(xtal_clk_pin),
      .rise_pulse(xtal_tick)
   );

   // ==========================================================
   // Bus decode
   // A single-bit write to the config register is not a legal
   // way to set it, so it is simply not taken.
   assign config_hit = cpu_bus.addr == CONFIG_ADDR;
   assign key_hit = cpu_bus.addr == KEY_ADDR;
   assign config_first = cpu_bus.wr & config_hit & ~cpu_bus.bit_op & ~config_written;
   assign config_second = cpu_bus.wr & config_hit & ~cpu_bus.bit_op & config_written;
   assign key_good = cpu_bus.wr & key_hit & ~cpu_bus.bit_op
                     & (cpu_bus.wdata == KEY_CLEAR_VALUE);
   // Any single-bit touch of the key register, read or write, counts as misuse
   assign key_bad = key_hit & ((cpu_bus.bit_op & (cpu_bus.wr | cpu_bus.rd))
                    | (cpu_bus.wr & ~cpu_bus.bit_op
                       & (cpu_bus.wdata != KEY_CLEAR_VALUE)));
   assign illegal = config_second | key_bad;

   // ==========================================================
   // Configuration register: reset value, then one write only
   assign next_config = accept_config(cpu_bus.wdata);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_config <= CONFIG_RESET;
         config_written <= 1'b0;
      end else if (config_first) begin
         watchdog_config <= next_config;
         config_written <= 1'b1;
      end
   end

   // ==========================================================
   // Halt-stop latch
   // Kept separately from the config bit so that nothing can
   // bring a halted watchdog back short of a chip reset.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         halt_stopped <= 1'b0;
      end else if (!ALWAYS_RUN && config_first && next_config[HALT_BIT]) begin
         halt_stopped <= 1'b1;
      end
   end

   // ==========================================================
   // Source selection and activity
   assign use_crystal = ~ALWAYS_RUN & watchdog_config[SOURCE_BIT];
   assign source_tick = use_crystal ? xtal_tick : osc_tick;

   // The source counts as halted while its clock is withheld from
   // the watchdog; deferred resets wait for this to come back.
   always_comb begin
      if (ALWAYS_RUN) begin
         source_active = 1'b1;
      end else if (halt_stopped) begin
         source_active = 1'b0;
      end else if (power.halt || power.stop || phase != PHASE_RUN) begin
         source_active = 1'b0;
      end else if (use_crystal) begin
         source_active = power.xtal_running;
      end else begin
         source_active = power.osc_enabled;
      end
   end

   // ==========================================================
   // STOP tracking: note the clocks on entry, hold after release
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stop_on_crystal <= 1'b0;
         cpu_was_on_crystal <= 1'b0;
      end else if (phase == PHASE_RUN && power.stop) begin
         stop_on_crystal <= use_crystal;
         cpu_was_on_crystal <= power.cpu_on_crystal;
      end
   end

   always_comb begin
      next_phase = phase;
      case (phase)
         PHASE_RUN: begin
            if (!ALWAYS_RUN && power.stop) begin
               next_phase = PHASE_SLEEP;
            end
         end
         PHASE_SLEEP: begin
            if (!power.stop) begin
               // An oscillator source picks up at once on release
               next_phase = stop_on_crystal ? PHASE_SETTLE : PHASE_RUN;
            end
         end
         PHASE_SETTLE: begin
            if (power.settle_done) begin
               next_phase = PHASE_RUN;
            end else if (!cpu_was_on_crystal && power.cpu_on_crystal) begin
               next_phase = PHASE_RUN;
            end
         end
         default: begin
            next_phase = PHASE_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= PHASE_RUN;
      end else begin
         phase <= next_phase;
      end
   end

   // ==========================================================
   // Counter
   // The count is never cleared by HALT or STOP, only frozen;
   // a key or accepted config write clears it outright.
   assign count_tick = source_tick & source_active;
   assign counter_clear = key_good | config_first;
   assign tap = overflow_tap(watchdog_config[INTERVAL_MSB:INTERVAL_LSB], use_crystal);

   watchdog_counter #(
      .WIDTH(WIDTH)
   ) counter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clear(counter_clear),
      .tick(count_tick),
      .tap(tap),
      .count(wdt_count),
      .overflow(overflow)
   );

   // ==========================================================
   // Deferred misuse
   // Misuse seen while the source is held is remembered and fired
   // when the source returns; a halt-stop throws it away.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pending_reset <= 1'b0;
      end else if (halt_stopped) begin
         pending_reset <= 1'b0;
      end else if (illegal && !source_active) begin
         pending_reset <= 1'b1;
      end else if (source_active) begin
         pending_reset <= 1'b0;
      end
   end

   // ==========================================================
   // Internal reset request, one cycle wide for misuse, held high while overflow lasts
   // The chip reset that follows also clears this block, so the
   // pulse may repeat until that happens; that is harmless.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_reset <= 1'b0;
      end else if (halt_stopped) begin
         wdt_reset <= 1'b0;
      end else if (overflow && source_active) begin
         wdt_reset <= 1'b1;
      end else if (illegal && source_active) begin
         wdt_reset <= 1'b1;
      end else if (pending_reset && source_active) begin
         wdt_reset <= 1'b1;
      end else begin
         wdt_reset <= 1'b0;
      end
   end

   // ==========================================================
   // Read data
   // The key register has no storage: it always shows its reset
   // value, whatever was last written.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_rdata <= UNMAPPED_READ;
      end else if (cpu_bus.rd) begin
         if (config_hit) begin
            cpu_rdata <= watchdog_config;
         end else if (key_hit) begin
            cpu_rdata <= KEY_READ_VALUE;
         end else begin
            cpu_rdata <= UNMAPPED_READ;
         end
      end
   end

   // Constant key value stands in for the register's reset load
   // and is what every read of that address returns.
   // is met by KEY_READ_VALUE being fixed at 0x9a.
   // rests on software; bits 7:5 are stored as written.
   // rests on software servicing in STOP under ALWAYS_RUN.

endmodule : watchdog_core
`default_nettype wire

// File: tb/watchdog_core_assertions.sv
// Checker for the watchdog core: key, config and counter relations.
// Assumes it is bound to watchdog_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module watchdog_core_checker
   import watchdog_pkg::*;
#(
   parameter bit ALWAYS_RUN = 1'b0,
   parameter int WIDTH = COUNT_WIDTH
) (
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Async reset
   input wire watchdog_pkg::cpu_bus_type cpu_bus, // CPU access
   input wire logic [7:0] cpu_rdata, // Read data
   input wire watchdog_pkg::power_state_type power, // Power state
   input wire logic osc_clk_pin, // Oscillator pin
   input wire logic xtal_clk_pin, // Crystal pin
   input wire logic wdt_reset, // Reset request
   input wire logic [WIDTH-1:0] wdt_count // Counter
);
   logic cfg_seen;
   logic [7:0] cfg_val;
   logic cfgw;
   logic keyw;
   logic idle;
   logic osc_src;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Helpers: a full-byte write decodes, plus a copy of the first config
   assign cfgw = cpu_bus.wr && !cpu_bus.bit_op && cpu_bus.addr == CONFIG_ADDR;
   assign keyw = cpu_bus.wr && !cpu_bus.bit_op && cpu_bus.addr == KEY_ADDR;
   assign idle = !power.halt && !power.stop;
   assign osc_src = ALWAYS_RUN || cfg_val[4:3] == 2'h0;
   // Only the first write is kept, as the design must do
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_seen <= 1'b0;
         cfg_val <= CONFIG_RESET;
      end else if (cfgw && !cfg_seen) begin
         cfg_seen <= 1'b1;
         cfg_val <= cpu_bus.wdata;
      end
   end
   // ==========================================================
   // Assertions
   a_key_read_fixed: assert property (cpu_bus.rd && !cpu_bus.bit_op && cpu_bus.addr == KEY_ADDR
      |=> cpu_rdata == KEY_READ_VALUE) else $error("key read not fixed value");
   a_key_clear_count: assert property (keyw && cpu_bus.wdata == KEY_CLEAR_VALUE
      |=> wdt_count == '0) else $error("key write did not clear count");
   a_wrong_key_reset: assert property (keyw && cpu_bus.wdata != KEY_CLEAR_VALUE && idle && !cfg_seen
      |=> wdt_reset) else $error("wrong key gave no reset");
   a_bit_key_reset: assert property ((cpu_bus.wr || cpu_bus.rd) && cpu_bus.bit_op
      && cpu_bus.addr == KEY_ADDR && idle && !cfg_seen |=> wdt_reset) else $error("bit access gave no reset");
   a_second_cfg_reset: assert property (cfgw && cfg_seen && !cfg_val[HALT_BIT] && osc_src && idle
      |=> wdt_reset) else $error("second config write gave no reset");
   a_first_cfg_clear: assert property (cfgw && !cfg_seen |=> wdt_count == '0)
      else $error("config write did not clear count");
   a_halt_stop_quiet: assert property (!ALWAYS_RUN && cfg_seen && cfg_val[HALT_BIT] |=> !wdt_reset)
      else $error("reset while halt-stopped");
   a_halt_freeze: assert property (!ALWAYS_RUN && power.halt && !keyw && !cfgw
      |=> $stable(wdt_count)) else $error("count moved in halt");
   a_osc_overflow: assert property (cfg_seen && osc_src && cfg_val[2:0] == 3'h0
      && wdt_count[OSC_BASE_EXP] && idle |=> wdt_reset) else $error("overflow gave no reset");
   c_overflow: cover property (wdt_count[OSC_BASE_EXP] && wdt_reset);
   c_halt: cover property (power.halt && wdt_count != '0);
   c_stop: cover property (power.stop ##1 !power.stop);
endmodule : watchdog_core_checker
bind watchdog_core watchdog_core_checker #(.ALWAYS_RUN(ALWAYS_RUN), .WIDTH(WIDTH)) chk_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .cpu_bus(cpu_bus), .cpu_rdata(cpu_rdata),
   .power(power), .osc_clk_pin(osc_clk_pin), .xtal_clk_pin(xtal_clk_pin),
   .wdt_reset(wdt_reset), .wdt_count(wdt_count));
`default_nettype wire

// File: tb/watchdog_timer_with_clear_key_bench.sv
// Self-checking bench for the watchdog core, stoppable and always-run builds.
// Assumes pin clocks at core/8 driven by the bench itself.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_with_clear_key_bench;
   import watchdog_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   cpu_bus_type bus = '0;
   power_state_type pw = 6'h0b;
   logic osc_clk_pin = 1'b0;
   logic xtal_clk_pin = 1'b0;
   logic xtal_on = 1'b1;
   logic [2:0] pdiv = 3'h0;
   logic [7:0] cpu_rdata;
   logic [7:0] ar_rdata;
   logic wdt_reset;
   logic [COUNT_WIDTH-1:0] wdt_count;
   logic [COUNT_WIDTH-1:0] ar_count;
   logic [COUNT_WIDTH-1:0] c;
   logic [31:0] seed = 32'h0000db58; // Xorshift start, 56152
   logic [7:0] exp_q[$];
   logic rd_d = 1'b0;
   int miscompares = 0;
   int n_tests = 0;
   watchdog_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .cpu_bus(bus), .cpu_rdata(cpu_rdata),
      .power(pw), .osc_clk_pin(osc_clk_pin), .xtal_clk_pin(xtal_clk_pin), .wdt_reset(wdt_reset),
      .wdt_count(wdt_count));
   // Always-run build on the same stimulus, for the fixed-source rules
   watchdog_core #(.ALWAYS_RUN(1'b1)) dut_always (.core_clk(core_clk), .sys_rst(sys_rst), .cpu_bus(bus),
      .cpu_rdata(ar_rdata), .power(pw), .osc_clk_pin(osc_clk_pin), .xtal_clk_pin(xtal_clk_pin),
      .wdt_reset(), .wdt_count(ar_count));
   // ==========================================================
   // Clock, and slow pin clocks well under a quarter of it
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      pdiv <= pdiv + 3'h1;
      osc_clk_pin <= pdiv[2];
      xtal_clk_pin <= xtal_on & ~pdiv[2];
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         miscompares++;
      end
   endtask : chk
   task automatic stop_test;
      $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   // Wrong key never equal to the clear code
   function automatic logic [7:0] bad_key();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return (seed[7:0] == KEY_CLEAR_VALUE) ? 8'h00 : seed[7:0];
   endfunction : bad_key
   // One byte access; a read notes its expected data for the watcher
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b,
         input logic [7:0] e);
      @(negedge core_clk);
      bus = '{addr: a, wr: w, rd: !w, bit_op: b, wdata: d};
      if (!w && !b) exp_q.push_back(e);
      @(negedge core_clk);
      bus.wr = 1'b0;
      bus.rd = 1'b0;
   endtask : acc
   task automatic rst;
      sys_rst = 1'b1;
      pw = 6'h0b;
      xtal_on = 1'b1;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
   endtask : rst
   // Bounded watch for the reset request; a missing one ends the run
   task automatic watch(input int n, input logic e);
      logic s;
      s = 1'b0;
      repeat (n) begin
         @(negedge core_clk);
         if (wdt_reset === 1'b1) s = 1'b1;
         if (s && e) break;
      end
      chk(s, e);
      if (e && !s) stop_test();
   endtask : watch
   task automatic hold(input int n);
      repeat (n) @(negedge core_clk);
   endtask : hold
   // ==========================================================
   // Watcher: read data lands one cycle after the strobe
   always @(posedge core_clk) rd_d <= bus.rd && !bus.bit_op && !sys_rst;
   always @(negedge core_clk) begin
      if (rd_d) chk(cpu_rdata, exp_q.pop_front());
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst();
      acc(0, KEY_ADDR, 0, 0, KEY_READ_VALUE);
      acc(0, CONFIG_ADDR, 0, 0, CONFIG_RESET);
      acc(0, 16'h0000, 0, 0, UNMAPPED_READ);
      hold(100);
      chk(wdt_count !== '0, 1);
      acc(1, KEY_ADDR, KEY_CLEAR_VALUE, 0, 0);
      chk(wdt_count, 0);
      acc(0, KEY_ADDR, 0, 0, KEY_READ_VALUE);
      // Several random wrong keys, each from a fresh reset
      repeat (3) begin
         rst();
         acc(1, KEY_ADDR, bad_key(), 0, 0);
         chk(wdt_reset, 1);
      end
      rst();
      acc(1, KEY_ADDR, KEY_CLEAR_VALUE, 1, 0);
      chk(wdt_reset, 1);
      // Halt freezes the count; a misuse meanwhile waits for the clock
      rst();
      hold(60);
      pw.halt = 1'b1;
      hold(1);
      c = wdt_count;
      hold(40);
      chk(wdt_count, c);
      acc(1, KEY_ADDR, bad_key(), 0, 0);
      chk(wdt_reset, 0);
      pw.halt = 1'b0;
      watch(20, 1);
      // Give the slow source time for a few ticks before looking
      hold(20);
      chk(wdt_count > c, 1);
      // CPU on crystal, watchdog on oscillator: resume at once after STOP
      rst();
      hold(60);
      pw.cpu_on_crystal = 1'b1;
      pw.settle_done = 1'b0;
      pw.stop = 1'b1;
      hold(2);
      c = wdt_count;
      hold(30);
      chk(wdt_count, c);
      pw.stop = 1'b0;
      hold(30);
      chk(wdt_count > c, 1);
      // Crystal source; both on crystal wait for settling after STOP
      rst();
      xtal_on = 1'b0;
      // Let a crystal edge still in the synchroniser drain first
      hold(4);
      acc(1, CONFIG_ADDR, 8'h68, 0, 0);
      chk(wdt_count, 0);
      acc(0, CONFIG_ADDR, 0, 0, 8'h68);
      hold(40);
      chk(wdt_count, 0);
      xtal_on = 1'b1;
      hold(40);
      chk(wdt_count !== '0, 1);
      pw.cpu_on_crystal = 1'b1;
      pw.settle_done = 1'b0;
      pw.stop = 1'b1;
      hold(4);
      pw.stop = 1'b0;
      c = wdt_count;
      hold(40);
      chk(wdt_count, c);
      pw.settle_done = 1'b1;
      hold(40);
      chk(wdt_count > c, 1);
      // Oscillator CPU, crystal watchdog: switching the CPU ends the wait
      pw.cpu_on_crystal = 1'b0;
      pw.settle_done = 1'b0;
      pw.stop = 1'b1;
      hold(4);
      pw.stop = 1'b0;
      c = wdt_count;
      hold(40);
      chk(wdt_count, c);
      pw.cpu_on_crystal = 1'b1;
      hold(40);
      chk(wdt_count > c, 1);
      acc(1, CONFIG_ADDR, 8'h60, 0, 0);
      chk(wdt_reset, 1);
      // Halt-stopped: every misuse stays silent, even with bit 4 cleared
      rst();
      acc(1, CONFIG_ADDR, 8'h70, 0, 0);
      acc(0, CONFIG_ADDR, 0, 0, 8'h70);
      chk(ar_rdata, 8'h60);
      c = wdt_count;
      acc(1, CONFIG_ADDR, 8'h60, 0, 0);
      chk(wdt_reset, 0);
      acc(1, KEY_ADDR, bad_key(), 0, 0);
      chk(wdt_reset, 0);
      acc(1, KEY_ADDR, KEY_CLEAR_VALUE, 1, 0);
      chk(wdt_reset, 0);
      watch(40, 0);
      chk(wdt_count, c);
      // Always-run build: crystal off and CPU in STOP, yet it counts on
      xtal_on = 1'b0;
      pw.stop = 1'b1;
      c = ar_count;
      hold(40);
      chk(ar_count > c, 1);
      acc(1, KEY_ADDR, KEY_CLEAR_VALUE, 0, 0);
      chk(ar_count, 0);
      // Shortest oscillator interval: 2048 ticks at eight cycles each
      rst();
      acc(1, CONFIG_ADDR, 8'h60, 0, 0);
      watch(16300, 0);
      watch(200, 1);
      chk(wdt_count[OSC_BASE_EXP], 1);
      stop_test();
   end
endmodule : watchdog_timer_with_clear_key_bench
`default_nettype wire
